// *** rtl/shc_pkg.sv ***
// constants for the system handler control and status register block
package shc_pkg;
  localparam logic [11:0] addr_shcsr = 12'h000;
  localparam logic [31:0] shcsr_reset = 32'h0000_0000;
  localparam int bit_usage_fault_enable = 18;
  localparam int bit_bus_fault_enable = 17;
  localparam int bit_mem_manage_fault_enable = 16;
  localparam int bit_supervisor_call_pending = 15;
  localparam int bit_bus_fault_pending = 14;
  localparam int bit_mem_manage_fault_pending = 13;
  localparam int bit_usage_fault_pending = 12;
  localparam int bit_tick_timer_handler_active = 11;
  localparam int bit_pendable_service_active = 10;
  localparam int bit_debug_monitor_active = 8;
  localparam int bit_supervisor_call_active = 7;
  localparam int bit_usage_fault_active = 3;
  localparam int bit_bus_fault_active = 1;
  localparam int bit_mem_manage_fault_active = 0;
  // implemented bits; everything else is reserved
  localparam logic [31:0] shcsr_mask = 32'h0007_fd8b;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// *** rtl/shc_ctrl_status.sv ***
// system handler control and status register with axi4-lite slave and hardware event ports
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
module shc_ctrl_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // one-cycle set and clear pulses from the exception core, same clock
  input wire logic [31:0] hw_set,
  input wire logic [31:0] hw_clr,
  output logic [31:0] shcsr_value
);
  // write channel
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic [31:0] bytemask;
  // high for the one cycle in which a held write is applied
  logic do_write;
  logic write_hit;

  // read channel
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic arready, next_arready;
  logic read_hit;

  // register proper; next_shcsr is built bit by bit below
  logic [31:0] shcsr;
  logic [31:0] soft_value;
  wire logic [31:0] next_shcsr;

  // limitation: the readies are registered and stay up while clk_en is low, so a master
  // must not finish a handshake in a frozen cycle; it would be lost without an answer

  // byte lanes of the write strobe, widened to a bit mask
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign bytemask[8*i +: 8] = {8{w_strb[i]}};
  end

  // a write lands once both halves are in and the previous response has been taken
  assign do_write = aw_held && w_held && !bvalid;
  assign write_hit = aw_addr[11:2] == shc_pkg::addr_shcsr[11:2];

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    // address and data are taken in either order and held until both are in
    if (s_axi_awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end

    if (s_axi_wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end

    // a new response cannot be raised until the old one has been taken
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      // unmapped offsets answer with an error and leave the register alone
      if (write_hit) begin
        next_bresp = shc_pkg::resp_okay;
      end else begin
        next_bresp = shc_pkg::resp_slverr;
      end
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end

    // readies are registered, so they follow the held state one cycle ahead
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // reset leaves the readies low; they come up at the first enabled edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= shc_pkg::resp_okay;
    end else if (clk_en) begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  // one read at a time: the address is refused while a response is still standing
  assign read_hit = s_axi_araddr[11:2] == shc_pkg::addr_shcsr[11:2];

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    // the read data is a snapshot of the register at the edge that takes the address
    if (s_axi_arvalid && arready) begin
      next_rvalid = 1'b1;
      if (read_hit) begin
        next_rdata = shcsr & shc_pkg::shcsr_mask;
        next_rresp = shc_pkg::resp_okay;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = shc_pkg::resp_slverr;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  // rdata and rresp hold with rvalid until the master takes them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= shc_pkg::resp_okay;
      arready <= 1'b0;
    end else if (clk_en) begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      arready <= next_arready;
    end
  end

  // software value: written lanes of implemented bits take the bus data, others keep state;
  // a write with no strobe set answers okay and changes nothing
  always_comb begin
    soft_value = shcsr;
    if (do_write && write_hit) begin
      soft_value = (shcsr & ~(bytemask & shc_pkg::shcsr_mask)) |
                   (w_data & bytemask & shc_pkg::shcsr_mask);
    end
  end

  // hardware events ride on top of the software value: a set beats a clear,
  // and both beat a write in the same cycle, so an exception that strikes
  // in a cycle with clk_en high while software rewrites the register is never lost
  for (genvar n = 0; n < 32; n++) begin : g_bit
    if (shc_pkg::shcsr_mask[n]) begin : g_used
      assign next_shcsr[n] = hw_set[n] || (soft_value[n] && !hw_clr[n]);
    end else begin : g_rsvd
      // reserved bits are tied low, so neither software nor events can set them
      assign next_shcsr[n] = 1'b0;
    end
  end

  // the output copy loads from the same next value, so it never lags
  // the stored register by a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shcsr <= shc_pkg::shcsr_reset;
      shcsr_value <= shc_pkg::shcsr_reset;
    end else if (clk_en) begin
      shcsr <= next_shcsr;
      shcsr_value <= next_shcsr;
    end
  end

  // bus outputs are the channel flops themselves
  assign s_axi_awready = awready;
  assign s_axi_wready = wready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
endmodule // shc_ctrl_status

// *** sim/shc_ctrl_status_monitor.sv ***
// port checker for the handler control and status register
module shc_ctrl_status_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] hw_set,
  input wire logic [31:0] hw_clr,
  input wire logic [31:0] shcsr_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rsvd_zero_a: assert property ((shcsr_value & ~shc_pkg::shcsr_mask) == '0) else $error("reserved");
  enable_set_a: assert property (clk_en && hw_set[18] |=> shcsr_value[18]) else $error("enable");
  pend_set_a: assert property (clk_en && hw_set[15] |=> shcsr_value[15]) else $error("pend set");
  pend_clear_a: assert property (clk_en && hw_clr[12] && !hw_set[12] |=> !shcsr_value[12]) else $error("pend");
  tick_active_a: assert property (clk_en && hw_set[11] |=> shcsr_value[11]) else $error("tick");
  mem_active_a: assert property (clk_en && hw_set[0] |=> shcsr_value[0]) else $error("active");
  // a bus write lands on the edge that raises the response
  change_cause_a: assert property ($changed(shcsr_value) |-> $past(hw_set) != '0 || $past(hw_clr) != '0 || $rose(s_axi_bvalid))
    else $error("cause");
  cover property ($rose(s_axi_bvalid));
  cover property (!clk_en && hw_set != '0);
  cover property (clk_en && hw_clr[12]);
endmodule // shc_ctrl_status_monitor
bind shc_ctrl_status shc_ctrl_status_monitor u_mon (
  .aclk(aclk),
  .aresetn(aresetn),
  .clk_en(clk_en),
  .s_axi_bvalid(s_axi_bvalid),
  .hw_set(hw_set),
  .hw_clr(hw_clr),
  .shcsr_value(shcsr_value)
);

// *** sim/shc_ctrl_status_tb.sv ***
// bench for the handler control and status register
module shc_ctrl_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = '0, aresetn = '0, clk_en = '1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, p, q, r;
  logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, hw_set = '0, hw_clr = '0, s_axi_rdata, shcsr_value, m = '0, d, b, rd;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, x;
  int num_errors = 0, compares = 0;
  always #2 aclk = ~aclk;
  shc_ctrl_status DUT (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .hw_set(hw_set),
    .hw_clr(hw_clr),
    .shcsr_value(shcsr_value)
  );
  task chk(string n, logic [33:0] e, logic [33:0] g);
    compares++;
    num_errors += int'(g !== e);
    if (g !== e) $display("unexpected %s expected %h seen %h", n, e, g);
  endtask
  // one bus cycle; p address, q response, r write data still owed
  task acc(logic w, logic [11:0] a, logic [31:0] v, logic [3:0] st);
    {p, q, r} = {2'h3, w};
    x = a[11:2] != shc_pkg::addr_shcsr[11:2] ? shc_pkg::resp_slverr : shc_pkg::resp_okay;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, v, st};
    while (p || q || r) begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {p & w, r, q & w, p & !w, q & !w};
      @(posedge aclk);
      if (q && (w ? s_axi_bvalid : s_axi_rvalid))
        chk("resp", {x, w || x != '0 ? 32'h0 : m}, w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata});
      if (q && !w && s_axi_rvalid) rd = s_axi_rdata;
      {p, q, r} = {p & !(w ? s_axi_awready : s_axi_arready), q & !(w ? s_axi_bvalid : s_axi_rvalid), r & !s_axi_wready};
    end
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    b = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    if (w && x == '0) m = (m & ~b | v & b) & shc_pkg::shcsr_mask;
  endtask
  task test_done;
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #12000 num_errors++;
    test_done;
  end
  initial begin
    void'($urandom(32'h69c25860));
    repeat (5) @(posedge aclk);
    aresetn <= '1;
    acc(1'h0, 12'h000, '0, '0);
    repeat (40) begin
      {d, b} = {$urandom, $urandom};
      acc(1'h1, 12'h000, d, b[3:0]);
      acc(1'h0, 12'h000, '0, '0);
      {d, b} = {$urandom, $urandom};
      // a frozen clock enable must swallow the pulses
      {hw_set, hw_clr, clk_en} <= {d, b, b[0] | b[1]};
      @(posedge aclk);
      {hw_set, hw_clr, clk_en} <= {64'h0, 1'h1};
      if (b[0] | b[1]) m = (m & ~b | d) & shc_pkg::shcsr_mask;
      @(negedge aclk) chk("value", 34'(m), 34'(shcsr_value));
    end
    // software reads, keeps every other bit, the active ones too, and flips one enable
    acc(1'h0, 12'h000, '0, '0);
    acc(1'h1, 12'h000, rd ^ (32'h1 << shc_pkg::bit_bus_fault_enable), 4'hf);
    acc(1'h0, 12'h000, '0, '0);
    // a second reset in mid-run returns the register to its reset value
    aresetn <= '0;
    repeat (5) @(posedge aclk);
    aresetn <= '1;
    m = shc_pkg::shcsr_reset;
    acc(1'h0, 12'h000, '0, '0);
    acc(1'h1, 12'h004, '1, 4'hf);
    acc(1'h0, 12'h004, '0, '0);
    acc(1'h0, 12'h000, '0, '0);
    test_done;
  end
endmodule // shc_ctrl_status_tb
